/* File: logic/spief_defines.svh */
// Register offsets, field positions, reset values and codes of the serial unit
`ifndef SPIEF_DEFINES_SVH
`define SPIEF_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SPIEF_OFS_CTRL    8'h00
`define SPIEF_OFS_MODE    8'h04
`define SPIEF_OFS_STATUS  8'h08
`define SPIEF_OFS_TXDATA  8'h0C
`define SPIEF_OFS_RXDATA  8'h10
`define SPIEF_OFS_PORT    8'h14
`define SPIEF_OFS_DIV     8'h18

// ****************************************
// Field positions
// ****************************************
`define SPIEF_CTRL_TXIE   7
`define SPIEF_CTRL_RXIE   6
`define SPIEF_CTRL_TXEN   5
`define SPIEF_CTRL_RXEN   4
`define SPIEF_CTRL_TENDIE 2
`define SPIEF_CTRL_CSHI   1
`define SPIEF_CTRL_CSLO   0
`define SPIEF_MODE_SYNC   7
`define SPIEF_MODE_PAREN  5
`define SPIEF_MODE_PARODD 4
`define SPIEF_ST_TXEMPTY  7
`define SPIEF_ST_RXFULL   6
`define SPIEF_ST_OVERRUN  5
`define SPIEF_ST_FRAMING  4
`define SPIEF_ST_PARITY   3
`define SPIEF_ST_TXEND    2
`define SPIEF_PORT_DATA   0
`define SPIEF_PORT_DIR    1

// ****************************************
// Reset values, timing and bus codes
// ****************************************
`define SPIEF_CTRL_RST    8'h00
`define SPIEF_MODE_RST    8'h00
`define SPIEF_PORT_RST    8'h00
`define SPIEF_DIV_RST     8'h0F
`define SPIEF_OVERSAMPLE  16
`define SPIEF_MID_TICK    4'h7
`define SPIEF_LAST_TICK   4'hF
`define SPIEF_HALF_TICK   4'h8
`define SPIEF_RESP_OKAY   2'h0
`define SPIEF_RESP_SLVERR 2'h2

`endif

/* File: logic/spief_pkg.sv */
// Types shared by the serial unit modules
package spief_pkg;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } spief_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_RUN  = 2'b10
  } spief_rx_e;

endpackage

/* File: logic/spief_tick_gen.sv */
// Sampling tick divider: one pulse every divisor+1 clocks
`timescale 1ns/1ps
module spief_tick_gen #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] divisor,
  input  wire logic         run,
  output logic              tick
);

  logic [W-1:0] count;

  // ****************************************
  // Down counter, reloaded when stopped so the first tick is a full period
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= divisor;
      tick  <= 1'b0;
    end else if (count == '0) begin
      count <= divisor;
      tick  <= 1'b1;
    end else begin
      count <= count - W'(1);
      tick  <= 1'b0;
    end
  end

endmodule

/* File: logic/spief_serial_unit.sv */
// Serial unit: AXI4-Lite registers, transmitter, receiver, flags and interrupts
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "spief_defines.svh"

// Overview of operation
// - Four sources share one interrupt output
// - Transmit-empty request when flag and enable set
// - Transmit-end request when flag and enable set
// - Transmit-empty flag resets to one
// - Transmit-end flag resets to one
// - Receive-full request when flag and enable set
// - Error request when any error flag set and receive interrupt enable (RXIE) set
// - Data write clears empty; shift load sets
// - Data writes always accepted, overwrite pending byte
// - Overrun sets flag, received byte not transferred
// - Framing/parity errors still transfer the byte
// - Errors leave receive-full; read clears it
// - Break keeps receiving, framing flag sets again
// - Transmit disable resets transmitter, pin to port
// - Sync transmit blocked while error flags set
// - Receive disable keeps error flags
// - Async receive at 16x, start on any low sample
// - Data bits latched at eighth sampling tick
// - Frame end with full flag means overrun
// - Receive data read clears receive-full flag
// - Clock pin low briefly when released
// - Sync data pin high one cycle released
// - Empty at last bit sets end, holds level
module spief_serial_unit #(
  parameter int DIV_W = 8
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxdPin,
  output logic             txdOut,
  output logic             txdOe,
  output logic             sckOut,
  output logic             sckOe,
  output logic             rxFullIrq,
  output logic             txEmptyIrq,
  output logic             txEndIrq,
  output logic             rxErrorIrq,
  output logic             irqOut
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]            ctrlReg;
  logic [7:0]            modeReg;
  logic [7:0]            portReg;
  logic [DIV_W-1:0]      divReg;
  logic [7:0]            txData;
  logic [7:0]            rxData;
  logic                  txEmpty;
  logic                  txEnd;
  logic                  rxFull;
  logic                  overrun;
  logic                  framing;
  logic                  parityErr;
  logic                  awHave;
  logic                  wHave;
  logic [7:0]            awAddr;
  logic [7:0]            wData;
  logic                  wLane0;
  spief_pkg::spief_tx_e  txState;
  spief_pkg::spief_rx_e  rxState;
  logic [3:0]            txPhase;
  logic [2:0]            txIdx;
  logic [7:0]            txShift;
  logic                  txPar;
  logic                  txLine;
  logic [3:0]            rxPhase;
  logic [3:0]            rxIdx;
  logic [7:0]            rxShift;
  logic                  rxParBit;
  logic                  rxDone;
  logic                  rxFrameBad;
  logic                  rxParBad;
  logic                  rxdMeta;
  logic                  rxdSync;
  logic                  txEnPrev;
  logic                  sckDrvPrev;
  logic                  sampleTick;

  // ****************************************
  // Control field decode
  // ****************************************
  wire txEnable   = ctrlReg[`SPIEF_CTRL_TXEN];
  wire rxEnable   = ctrlReg[`SPIEF_CTRL_RXEN];
  wire syncMode   = modeReg[`SPIEF_MODE_SYNC];
  wire parEnable  = modeReg[`SPIEF_MODE_PAREN] & ~syncMode;
  wire parOdd     = modeReg[`SPIEF_MODE_PARODD];
  wire anyErr     = overrun | framing | parityErr;
  wire clkSelHi   = ctrlReg[`SPIEF_CTRL_CSHI];

  // ****************************************
  // Bus decode
  // ****************************************
  wire doWrite    = awHave & wHave & ~s_axi_bvalid;
  wire wrLane     = doWrite & wLane0;
  wire wrCtrl     = wrLane & (awAddr == `SPIEF_OFS_CTRL);
  wire wrMode     = wrLane & (awAddr == `SPIEF_OFS_MODE);
  wire wrStatus   = wrLane & (awAddr == `SPIEF_OFS_STATUS);
  wire wrTxData   = wrLane & (awAddr == `SPIEF_OFS_TXDATA);
  wire wrPort     = wrLane & (awAddr == `SPIEF_OFS_PORT);
  wire wrDiv      = wrLane & (awAddr == `SPIEF_OFS_DIV);
  wire wAddrOk    = (awAddr == `SPIEF_OFS_CTRL) | (awAddr == `SPIEF_OFS_MODE) |
                    (awAddr == `SPIEF_OFS_STATUS) | (awAddr == `SPIEF_OFS_TXDATA) |
                    (awAddr == `SPIEF_OFS_RXDATA) | (awAddr == `SPIEF_OFS_PORT) |
                    (awAddr == `SPIEF_OFS_DIV);
  wire rdTake     = s_axi_arvalid & s_axi_arready;
  wire rdRxData   = rdTake & (s_axi_araddr == `SPIEF_OFS_RXDATA);
  wire [7:0] statusView = {txEmpty, rxFull, overrun, framing, parityErr, txEnd, 2'b00};
  wire [7:0] rdByte =
    (s_axi_araddr == `SPIEF_OFS_CTRL)   ? ctrlReg :
    (s_axi_araddr == `SPIEF_OFS_MODE)   ? modeReg :
    (s_axi_araddr == `SPIEF_OFS_STATUS) ? statusView :
    (s_axi_araddr == `SPIEF_OFS_TXDATA) ? txData :
    (s_axi_araddr == `SPIEF_OFS_RXDATA) ? rxData :
    (s_axi_araddr == `SPIEF_OFS_PORT)   ? portReg :
    (s_axi_araddr == `SPIEF_OFS_DIV)    ? 8'(divReg) : 8'h00;
  wire rAddrOk    = (s_axi_araddr == `SPIEF_OFS_CTRL) | (s_axi_araddr == `SPIEF_OFS_MODE) |
                    (s_axi_araddr == `SPIEF_OFS_STATUS) | (s_axi_araddr == `SPIEF_OFS_TXDATA) |
                    (s_axi_araddr == `SPIEF_OFS_RXDATA) | (s_axi_araddr == `SPIEF_OFS_PORT) |
                    (s_axi_araddr == `SPIEF_OFS_DIV);

  // ****************************************
  // Transmit sequencing terms
  // ****************************************
  wire txBitEnd   = sampleTick & (txPhase == `SPIEF_LAST_TICK);
  wire txLastBit  = (txState == spief_pkg::TX_STOP) |
                    ((txState == spief_pkg::TX_DATA) & syncMode & (txIdx == 3'h7));
  // Never load in the cycle of a data write, so the fresh byte is not lost
  wire txReady    = ~txEmpty & ~wrTxData & ~(syncMode & anyErr);
  wire txTake     = txReady & ((txState == spief_pkg::TX_IDLE) | (txBitEnd & txLastBit));
  wire txFinish   = txBitEnd & txLastBit & txEmpty;
  wire syncSample = syncMode & rxEnable & (txState == spief_pkg::TX_DATA) &
                    sampleTick & (txPhase == `SPIEF_MID_TICK);
  wire sckDrive   = syncMode & ~clkSelHi & (txEnable | rxEnable);
  wire sckOwned   = syncMode & (clkSelHi | txEnable | rxEnable);
  wire sckLine    = ~((txState == spief_pkg::TX_DATA) & syncMode & (txPhase < `SPIEF_HALF_TICK));

  spief_tick_gen #(
    .W       (DIV_W)
  ) u_tick (
    .core_clk(core_clk),
    .rstn    (rstn),
    .divisor (divReg),
    .run     (txEnable | rxEnable),
    .tick    (sampleTick)
  );

  // ****************************************
  // Receive pin synchroniser
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxdMeta <= 1'b1;
      rxdSync <= 1'b1;
    end else begin
      rxdMeta <= rxdPin;
      rxdSync <= rxdMeta;
    end
  end

  // ****************************************
  // AXI4-Lite write channels; one write in flight at a time
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awHave        <= 1'b0;
      wHave         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 8'h00;
      wLane0        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPIEF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave        <= 1'b1;
        wData        <= s_axi_wdata[7:0];
        wLane0       <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHave       <= 1'b0;
        wHave        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wAddrOk ? `SPIEF_RESP_OKAY : `SPIEF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel; data reads as zero above the low byte
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SPIEF_RESP_OKAY;
    end else if (rdTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rdByte};
      s_axi_rresp   <= rAddrOk ? `SPIEF_RESP_OKAY : `SPIEF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Software control registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= `SPIEF_CTRL_RST;
      modeReg <= `SPIEF_MODE_RST;
      portReg <= `SPIEF_PORT_RST;
      divReg  <= DIV_W'(`SPIEF_DIV_RST);
      txData  <= 8'h00;
    end else begin
      if (wrCtrl) ctrlReg <= wData;
      if (wrMode) modeReg <= wData;
      if (wrPort) portReg <= wData;
      if (wrDiv) divReg <= DIV_W'(wData);
      if (wrTxData) txData <= wData;
    end
  end

  // ****************************************
  // Status flags: hardware set wins over a same-cycle clear
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txEmpty   <= 1'b1;
      txEnd     <= 1'b1;
      rxFull    <= 1'b0;
      overrun   <= 1'b0;
      framing   <= 1'b0;
      parityErr <= 1'b0;
      rxData    <= 8'h00;
    end else begin
      // Transfer into the shift register empties the holding byte
      txEmpty <= txTake | (txEmpty & ~wrTxData);
      txEnd   <= txFinish | (txEnd & ~wrTxData);
      // Only a full holding register turns a finished frame into an overrun
      if (rxDone && !rxFull) begin
        rxData <= rxShift;
      end
      rxFull    <= (rxDone & ~rxFull) | (rxFull & ~rdRxData);
      overrun   <= (rxDone & rxFull) |
                   (overrun & ~(wrStatus & ~wData[`SPIEF_ST_OVERRUN]));
      framing   <= (rxDone & rxFrameBad) |
                   (framing & ~(wrStatus & ~wData[`SPIEF_ST_FRAMING]));
      parityErr <= (rxDone & rxParBad) |
                   (parityErr & ~(wrStatus & ~wData[`SPIEF_ST_PARITY]));
    end
  end

  // ****************************************
  // Transmitter; disable forces idle from any state
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txState <= spief_pkg::TX_IDLE;
      txPhase <= 4'h0;
      txIdx   <= 3'h0;
      txShift <= 8'h00;
      txPar   <= 1'b0;
      txLine  <= 1'b1;
    end else if (!txEnable) begin
      txState <= spief_pkg::TX_IDLE;
      txPhase <= 4'h0;
      txIdx   <= 3'h0;
      txLine  <= 1'b1;
    end else begin
      if (sampleTick) txPhase <= txPhase + 4'h1;
      if (txTake) begin
        txShift <= txData;
        txPar   <= (^txData) ^ parOdd;
        txIdx   <= 3'h0;
        txPhase <= 4'h0;
        txState <= syncMode ? spief_pkg::TX_DATA : spief_pkg::TX_START;
      end else begin
        case (txState)
          spief_pkg::TX_IDLE: begin
            txPhase <= 4'h0; // Line keeps its final level while idle
          end
          spief_pkg::TX_START: begin
            txLine <= 1'b0;
            if (txBitEnd) txState <= spief_pkg::TX_DATA;
          end
          spief_pkg::TX_DATA: begin
            txLine <= txShift[0];
            if (txBitEnd) begin
              txShift <= {1'b0, txShift[7:1]};
              txIdx   <= txIdx + 3'h1;
              if (txIdx == 3'h7) begin
                txState <= syncMode ? spief_pkg::TX_IDLE :
                           parEnable ? spief_pkg::TX_PAR : spief_pkg::TX_STOP;
              end
            end
          end
          spief_pkg::TX_PAR: begin
            txLine <= txPar;
            if (txBitEnd) txState <= spief_pkg::TX_STOP;
          end
          spief_pkg::TX_STOP: begin
            txLine <= 1'b1;
            if (txBitEnd) txState <= spief_pkg::TX_IDLE;
          end
          default: begin
            txState <= spief_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Receiver: async frames at 16x, sync bits on clock rising edges
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxState    <= spief_pkg::RX_IDLE;
      rxPhase    <= 4'h0;
      rxIdx      <= 4'h0;
      rxShift    <= 8'h00;
      rxParBit   <= 1'b0;
      rxDone     <= 1'b0;
      rxFrameBad <= 1'b0;
      rxParBad   <= 1'b0;
    end else begin
      rxDone     <= 1'b0;
      rxFrameBad <= 1'b0;
      rxParBad   <= 1'b0;
      if (!rxEnable) begin
        rxState <= spief_pkg::RX_IDLE;
        rxIdx   <= 4'h0;
      end else if (syncMode) begin
        rxState <= spief_pkg::RX_IDLE;
        if (syncSample) begin
          rxShift <= {rxdSync, rxShift[7:1]};
          rxIdx   <= (rxIdx == 4'h7) ? 4'h0 : rxIdx + 4'h1;
          rxDone  <= (rxIdx == 4'h7);
        end
      end else begin
        case (rxState)
          spief_pkg::RX_IDLE: begin
            // Any low sample is taken as the start bit; a held break restarts at once
            if (sampleTick && !rxdSync) begin
              rxState <= spief_pkg::RX_RUN;
              rxPhase <= 4'h0;
              rxIdx   <= 4'h0;
            end
          end
          spief_pkg::RX_RUN: begin
            if (sampleTick) begin
              rxPhase <= rxPhase + 4'h1;
              if (rxPhase == `SPIEF_MID_TICK) begin
                rxIdx <= rxIdx + 4'h1;
                if (rxIdx == 4'h0) begin
                  if (rxdSync) rxState <= spief_pkg::RX_IDLE; // Glitch, not a start bit
                end else if (rxIdx <= 4'h8) begin
                  rxShift <= {rxdSync, rxShift[7:1]};
                end else if (parEnable && rxIdx == 4'h9) begin
                  rxParBit <= rxdSync;
                end else begin
                  rxDone     <= 1'b1;
                  rxFrameBad <= ~rxdSync;
                  rxParBad   <= parEnable & ((^rxShift) ^ rxParBit ^ parOdd);
                  rxState    <= spief_pkg::RX_IDLE;
                end
              end
            end
          end
          default: begin
            rxState <= spief_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Pin drivers with release glitches kept from the serial function
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txEnPrev   <= 1'b0;
      sckDrvPrev <= 1'b0;
      txdOut     <= 1'b1;
      txdOe      <= 1'b0;
      sckOut     <= 1'b1;
      sckOe      <= 1'b0;
    end else begin
      txEnPrev   <= txEnable;
      sckDrvPrev <= sckDrive;
      if (syncMode && txEnPrev && !txEnable) begin
        txdOut <= 1'b1;
        txdOe  <= 1'b1;
      end else begin
        txdOut <= txEnable ? txLine : portReg[`SPIEF_PORT_DATA];
        txdOe  <= txEnable | portReg[`SPIEF_PORT_DIR];
      end
      // A single core cycle is the shortest low pulse this clock can make
      if (sckDrvPrev && !sckOwned) begin
        sckOut <= 1'b0;
        sckOe  <= 1'b1;
      end else begin
        sckOut <= sckLine;
        sckOe  <= sckDrive;
      end
    end
  end

  // ****************************************
  // Interrupt requests, all merged onto one line
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txEmptyIrq <= 1'b0;
      txEndIrq   <= 1'b0;
      rxFullIrq  <= 1'b0;
      rxErrorIrq <= 1'b0;
      irqOut     <= 1'b0;
    end else begin
      txEmptyIrq <= txEmpty & ctrlReg[`SPIEF_CTRL_TXIE];
      txEndIrq   <= txEnd & ctrlReg[`SPIEF_CTRL_TENDIE];
      rxFullIrq  <= rxFull & ctrlReg[`SPIEF_CTRL_RXIE];
      rxErrorIrq <= anyErr & ctrlReg[`SPIEF_CTRL_RXIE];
      irqOut     <= (txEmpty & ctrlReg[`SPIEF_CTRL_TXIE]) | (txEnd & ctrlReg[`SPIEF_CTRL_TENDIE]) |
                    ((rxFull | anyErr) & ctrlReg[`SPIEF_CTRL_RXIE]);
    end
  end

endmodule

/* File: verif/spief_serial_unit_assertions.sv */
// Port assertions of the serial unit
`timescale 1ns/1ps
module spief_serial_unit_assertions (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        rxFullIrq,
  input wire logic        txEmptyIrq,
  input wire logic        txEndIrq,
  input wire logic        rxErrorIrq,
  input wire logic        irqOut
);
  // ****
  // One domain, reset quiets all
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Shared request follows the four
  a_irq_or_merge: assert property (irqOut == (rxFullIrq | txEmptyIrq | txEndIrq | rxErrorIrq))
    else $error("shared request not the OR");
  a_err_shared: assert property (rxErrorIrq |-> irqOut)
    else $error("error request not shared");
  // Bus answers come and stand
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule

bind spief_serial_unit spief_serial_unit_assertions chk_u (.core_clk, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rxFullIrq, .txEmptyIrq, .txEndIrq, .rxErrorIrq, .irqOut);

/* File: verif/spief_remote_uart.sv */
// Remote asynchronous sender on the receive line
`timescale 1ns/1ps
module spief_remote_uart #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic core_clk,
  output logic      rxd
);
  // Mark level between frames
  initial rxd = 1'h1;
  // Start, eight bits LSB first, stop, one idle bit; a low stop forces a framing fault
  task automatic send(input logic [7:0] d, input logic stopBit);
    logic [10:0] f;
    f = {1'h1, stopBit, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge core_clk);
    end
  endtask
endmodule

/* File: verif/serial_port_irq_and_error_flags_bench.sv */
// Self-checking bench of the serial unit
`timescale 1ns/1ps
module serial_port_irq_and_error_flags_bench;
  logic        core_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, txdOut, txdOe;
  logic        sckOut, sckOe, rxFullIrq, txEmptyIrq, txEndIrq, rxErrorIrq, irqOut;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  wire         rxdPin;
  int          nFail, comparisons, cycles;

  spief_serial_unit dut_u (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxdPin,
    .txdOut, .txdOe, .sckOut, .sckOe, .rxFullIrq, .txEmptyIrq, .txEndIrq, .rxErrorIrq, .irqOut);
  spief_remote_uart remote_u (.core_clk, .rxd(rxdPin));

  // 200 MHz clock and a hang limit
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      complete_run();
    end
  end

  // ****
  // Bus tasks and comparison
  // ****
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      nFail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge core_clk);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_tx();
    wr(8'h08, 8'h00);
    rd(8'h08);
    chk("status", d, 8'h84);
    rd(8'h1C);
    chk("resp", r, 8'h02);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h84);
    chk("txirq", txEmptyIrq, 8'h01);
    chk("endirq", txEndIrq, 8'h01);
    chk("irq", irqOut, 8'h01);
    wr(8'h00, 8'h20);
    chk("irq", irqOut, 8'h00);
    wr(8'h0C, 8'h55);
    rd(8'h08);
    chk("txstat", d & 8'h84, 8'h80);
    repeat (200) @(posedge core_clk);
    rd(8'h08);
    chk("status", d, 8'h84);
    chk("line", {txdOe, txdOut}, 8'h03);
    wr(8'h14, 8'h02);
    wr(8'h00, 8'h00);
    chk("break", {txdOe, txdOut}, 8'h02);
  endtask
  // Good frame, then an overrun left unread
  task automatic t_rx();
    wr(8'h00, 8'h50);
    remote_u.send(8'hA5, 1'h1);
    repeat (10) @(posedge core_clk);
    chk("rxirq", rxFullIrq, 8'h01);
    rd(8'h10);
    chk("rxdata", d, 8'hA5);
    rd(8'h08);
    chk("status", d, 8'h84);
    remote_u.send(8'h3C, 1'h1);
    remote_u.send(8'hC3, 1'h1);
    repeat (10) @(posedge core_clk);
    rd(8'h08);
    chk("status", d, 8'hE4);
    chk("errirq", rxErrorIrq, 8'h01);
    rd(8'h10);
    chk("rxdata", d, 8'h3C);
    rd(8'h08);
    chk("status", d, 8'hA4);
    wr(8'h00, 8'h40);
    rd(8'h08);
    chk("status", d, 8'hA4);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h50);
    remote_u.send(8'h81, 1'h0);
    repeat (10) @(posedge core_clk);
    rd(8'h08);
    chk("framing", d & 8'h70, 8'h50);
    rd(8'h10);
    chk("rxdata", d, 8'h81);
  endtask
  // Sync mode: errors hold off sending, MSB held, release glitches
  task automatic t_sync();
    wr(8'h04, 8'h80);
    wr(8'h00, 8'h20);
    wr(8'h0C, 8'h5A);
    rd(8'h08);
    chk("status", d, 8'h10);
    wr(8'h08, 8'h00);
    repeat (150) @(posedge core_clk);
    rd(8'h08);
    chk("status", d & 8'h84, 8'h84);
    chk("pins", {sckOe, sckOut, txdOe, txdOut}, 8'h0E);
    wr(8'h00, 8'h00);
    chk("pins", {sckOe, sckOut, txdOe, txdOut}, 8'h0B);
    @(posedge core_clk);
    chk("pins", {sckOe, sckOut, txdOe, txdOut}, 8'h06);
    wr(8'h1C, 8'h00);
    chk("bresp", r, 8'h02);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Idle bus, reset for five cycles, then the scenarios
  initial begin
    {nFail, comparisons, cycles} = 0;
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    t_tx();
    t_rx();
    t_sync();
    complete_run();
  end
endmodule
